// >>> core/rxfs_defines.vh
`ifndef RXFS_DEFINES_VH
`define RXFS_DEFINES_VH
// register byte offsets
`define RXFS_OFF_RXCTL 8'h76
`define RXFS_OFF_TXFREE 8'h78
`define RXFS_OFF_STATUS 8'h7c
`define RXFS_OFF_RXCTL1 8'h74
`define RXFS_OFF_POP 8'h7e
`define RXFS_OFF_IRQ_ST 8'h90
`define RXFS_OFF_IRQ_MASK 8'h92
// rx checksum control fields
`define RXFS_ZUDP_BIT 3
`define RXFS_LITE_BIT 2
`define RXFS_ICMP_BIT 1
`define RXFS_SAD_BIT 0
`define RXFS_RXCTL_RST 4'h4
// rx control 1 field
`define RXFS_PASSBAD_BIT 9
// frame status fields
`define RXFS_FV_BIT 15
`define RXFS_ICMP_BAD 13
`define RXFS_IP_BAD 12
`define RXFS_TCP_BAD 11
`define RXFS_UDP_BAD 10
`define RXFS_BCAST 7
`define RXFS_MCAST 6
`define RXFS_UCAST 5
`define RXFS_SYMERR 4
`define RXFS_FTYPE 3
`define RXFS_OVERSIZE 2
`define RXFS_RUNT 1
`define RXFS_CRC 0
// length limits
`define RXFS_ETHTYPE_MIN 16'd1500
`define RXFS_MAX_LEN 12'd2000
// interrupt bits: 0 frame stored, 1 frame dropped
`define RXFS_IRQ_W 2
`endif

// >>> core/rxfs_core.v
// How it works
// - zero udp checksum passes only if enabled
// - lite udp checksum checked when enabled
// - bad icmp checksum drops when checking
// - drop frames from our own address
// - transmit free space as 13 bits
// - valid bit only for complete frame
// - separate checksum error flags per protocol
// - destination class flags broadcast multicast unicast
// - symbol error flag per frame
// - ethernet type above 1500 else 802.3
// - oversize flagged, kept only if passing bad
// - runt flagged, kept only if passing bad
// - crc error kept only if passing bad
// - pass bad frames control bit
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
`include "rxfs_defines.vh"
module rxfs_core #(
  parameter DEPTH_LOG2 = 2,
  parameter TXW = 13
) (
  // clock and reset
  input wire sys_clk_i,
  input wire resetn_i,
  // register port
  input wire [7:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  // receive path: frame end summary, one pulse
  input wire fr_end_i,
  input wire [47:0] fr_sa_i,
  input wire [47:0] fr_da_i,
  input wire [15:0] fr_lentype_i,
  input wire [11:0] fr_len_i,
  input wire fr_crc_err_i,
  input wire fr_sym_err_i,
  input wire fr_runt_i,
  input wire fr_is_udp_i,
  input wire fr_is_lite_i,
  input wire fr_is_icmp_i,
  input wire fr_is_frag_i,
  input wire fr_udp_zero_i,
  input wire fr_icmp_bad_i,
  input wire fr_ip_bad_i,
  input wire fr_tcp_bad_i,
  input wire fr_udp_bad_i,
  // station address
  input wire [47:0] station_addr_i,
  // transmit queue free bytes from queue manager
  input wire [TXW-1:0] tx_free_bytes_i,
  // controls to rest of unit
  output wire lite_udp_checksum_enable_o,
  output wire pass_bad_frames_o,
  output wire frame_valid_o,
  output wire irq_o
);
  // status queue: one word per stored frame
  // a full queue drops the next frame
  // and raises the dropped interrupt bit
  localparam DEPTH = 1 << DEPTH_LOG2;
  // checksum control register bits 3..0
  reg [3:0] rxctl_q;
  // pass bad frames control
  reg passbad_q;
  // status queue storage
  reg [14:0] stq_mem [0:DEPTH-1];
  reg [DEPTH_LOG2:0] wp_q;
  reg [DEPTH_LOG2:0] rp_q;
  // interrupt status and mask
  reg [`RXFS_IRQ_W-1:0] ist_q;
  reg [`RXFS_IRQ_W-1:0] imask_q;
  // per-frame decisions
  reg [14:0] st_w;
  // low when a filter drops the frame
  reg keep_w;
  wire empty_w;
  wire full_w;
  wire pop_w;
  wire push_w;
  // udp flag after the lite bypass
  wire udp_bad_eff;
  wire bcast_w;
  // loop index for the clear bits
  integer i;

  // pointers carry one extra wrap bit
  // equal pointers: nothing stored
  assign empty_w = (wp_q == rp_q);
  // same slot on another lap: all slots used
  assign full_w = (wp_q[DEPTH_LOG2-1:0] == rp_q[DEPTH_LOG2-1:0]) &&
                  (wp_q[DEPTH_LOG2] != rp_q[DEPTH_LOG2]);
  assign pop_w = wr_i && (addr_i == `RXFS_OFF_POP) && !empty_w;
  // store at frame end when kept and room left
  // summary inputs matter only in that cycle
  assign push_w = fr_end_i && keep_w && !full_w;
  // lite frames bypass the check when disabled
  // lite check bypass
  assign udp_bad_eff = fr_udp_bad_i &&
    !(fr_is_lite_i && !rxctl_q[`RXFS_LITE_BIT]);
  // all ones destination is broadcast
  assign bcast_w = (fr_da_i == 48'hffffffffffff);
  // transmit side uses this to insert checksums
  assign lite_udp_checksum_enable_o = rxctl_q[`RXFS_LITE_BIT];
  // receive path lets bad frames through
  assign pass_bad_frames_o = passbad_q;
  // complete frames only enter the queue
  // valid only when a stored frame waits
  assign frame_valid_o = !empty_w;
  // level interrupt while an unmasked bit is set
  assign irq_o = |(ist_q & imask_q);

  // build status word and keep decision
  always @*
  begin
    // defaults keep reserved bits clear
    st_w = 15'h0000;
    st_w[`RXFS_ICMP_BAD] = fr_icmp_bad_i;
    st_w[`RXFS_IP_BAD] = fr_ip_bad_i;
    st_w[`RXFS_TCP_BAD] = fr_tcp_bad_i;
    st_w[`RXFS_UDP_BAD] = udp_bad_eff;
    // group bit of the first octet on the wire
    // address class flags
    st_w[`RXFS_BCAST] = bcast_w;
    st_w[`RXFS_MCAST] = fr_da_i[40];
    st_w[`RXFS_UCAST] = !fr_da_i[40];
    st_w[`RXFS_SYMERR] = fr_sym_err_i;
    // meaningless for runts, stored anyway
    // type above 1500
    st_w[`RXFS_FTYPE] = (fr_lentype_i > `RXFS_ETHTYPE_MIN);
    // length flagged, frame dropped unless passing bad
    // oversize, never truncated
    st_w[`RXFS_OVERSIZE] = (fr_len_i > `RXFS_MAX_LEN);
    st_w[`RXFS_RUNT] = fr_runt_i;
    st_w[`RXFS_CRC] = fr_crc_err_i;
    // keep unless a filter below drops it
    // each filter can drop on its own
    keep_w = 1'b1;
    if ((fr_crc_err_i || fr_runt_i || st_w[`RXFS_OVERSIZE]) && !passbad_q)
    begin
      keep_w = 1'b0;
    end
    // zero checksum means sender skipped it
    // zero udp checksum
    if (fr_is_udp_i && fr_udp_zero_i && !rxctl_q[`RXFS_ZUDP_BIT])
    begin
      keep_w = 1'b0;
    end
    // fragments cannot be checked, exempt from this drop
    // icmp checksum discard
    if (rxctl_q[`RXFS_ICMP_BIT] && fr_is_icmp_i && !fr_is_frag_i &&
        fr_icmp_bad_i)
    begin
      keep_w = 1'b0;
    end
    // drops our own frames echoed back
    // source address drop
    if (rxctl_q[`RXFS_SAD_BIT] && (fr_sa_i == station_addr_i))
    begin
      keep_w = 1'b0;
    end
  end

  // control registers and queue pointers
  // reset values: lite check on, all else off
  always @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      rxctl_q <= `RXFS_RXCTL_RST;
      passbad_q <= 1'b0;
      // status queue starts empty
      wp_q <= {(DEPTH_LOG2+1){1'b0}};
      rp_q <= {(DEPTH_LOG2+1){1'b0}};
      // all interrupts masked after reset
      imask_q <= {`RXFS_IRQ_W{1'b0}};
    end
    else
    begin
      // software writes
      // one strobe writes one register
      if (wr_i && addr_i == `RXFS_OFF_RXCTL)
      begin
        // bits above 3 are reserved, dropped
        rxctl_q <= wdata_i[3:0];
      end
      if (wr_i && addr_i == `RXFS_OFF_RXCTL1)
      begin
        // other bits of this word live elsewhere
        passbad_q <= wdata_i[`RXFS_PASSBAD_BIT];
      end
      if (wr_i && addr_i == `RXFS_OFF_IRQ_MASK)
      begin
        // mask has the layout of the status bits
        imask_q <= wdata_i[`RXFS_IRQ_W-1:0];
      end
      // queue movement
      // push and pop may fall in one cycle
      // each pointer moves on its own
      if (push_w)
      begin
        // wrap bit flips every full lap
        wp_q <= wp_q + 1'b1;
      end
      if (pop_w)
      begin
        // pop on empty was filtered out above
        rp_q <= rp_q + 1'b1;
      end
    end
  end

  // status memory, no reset needed
  // an empty slot is never shown to software
  // the read path masks it with the empty flag
  always @(posedge sys_clk_i)
  begin
    if (push_w)
    begin
      stq_mem[wp_q[DEPTH_LOG2-1:0]] <= st_w;
    end
  end

  // sticky interrupt status, set beats clear
  // bit 0 frame stored, bit 1 frame dropped
  always @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      // no events pending after reset
      ist_q <= {`RXFS_IRQ_W{1'b0}};
    end
    else
    begin
      // host writes ones to clear, zeros keep
      for (i = 0; i < `RXFS_IRQ_W; i = i + 1)
      begin
        if (wr_i && addr_i == `RXFS_OFF_IRQ_ST && wdata_i[i])
        begin
          ist_q[i] <= 1'b0;
        end
      end
      if (push_w)
      begin
        // sets come after clears so they win
        ist_q[0] <= 1'b1;
      end
      if (fr_end_i && !push_w)
      begin
        // filtered or no room in the queue
        ist_q[1] <= 1'b1;
      end
    end
  end

  // read data, one cycle after strobe
  // zero in every cycle without a read
  // so a stale word never lingers on the bus
  always @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      // nothing to show during reset
      rdata_o <= 16'h0000;
    end
    else if (rd_i)
    begin
      case (addr_i)
        // control bits, upper part reserved
        `RXFS_OFF_RXCTL: rdata_o <= {12'h000, rxctl_q};
        // live count from the queue manager
        // free byte count
        `RXFS_OFF_TXFREE: rdata_o <= {{(16-TXW){1'b0}}, tx_free_bytes_i};
        // head of the status queue
        `RXFS_OFF_STATUS:
        begin
          if (empty_w)
            rdata_o <= 16'h0000;
          else
            rdata_o <= {1'b1, stq_mem[rp_q[DEPTH_LOG2-1:0]] & 15'h3cff};
        end
        // pass bad frames alone in its word
        `RXFS_OFF_RXCTL1:
          rdata_o <= {6'h00, passbad_q, 9'h000};
        // interrupt status and mask
        `RXFS_OFF_IRQ_ST:
          rdata_o <= {{(16-`RXFS_IRQ_W){1'b0}}, ist_q};
        `RXFS_OFF_IRQ_MASK:
          rdata_o <= {{(16-`RXFS_IRQ_W){1'b0}}, imask_q};
        // unmapped and reserved offsets read zero
        default: rdata_o <= 16'h0000;
      endcase
    end
    else
    begin
      rdata_o <= 16'h0000;
    end
  end
endmodule

// >>> testbench/rxfs_core_props.sv
`timescale 1ns/1ns
module rxfs_core_props #(parameter TXW = 13) (
  // clock and reset
  input wire sys_clk_i,
  input wire resetn_i,
  // register port
  input wire [7:0] addr_i,
  input wire wr_i,
  input wire rd_i,
  input wire [15:0] rdata_o,
  // frame side
  input wire fr_end_i,
  input wire [TXW-1:0] tx_free_bytes_i,
  input wire lite_udp_checksum_enable_o,
  input wire pass_bad_frames_o,
  input wire frame_valid_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // reads of the status register
  wire st_rd = rd_i && addr_i == 8'h7c;
  property p_idle; !$past(rd_i) |-> rdata_o == 16'h0000; endproperty
  property p_tx; rd_i && addr_i == 8'h78 |=>
    rdata_o == {{(16-TXW){1'b0}}, $past(tx_free_bytes_i)}; endproperty
  property p_lite; $changed(lite_udp_checksum_enable_o) |->
    $past(wr_i && addr_i == 8'h76); endproperty
  property p_pass; $changed(pass_bad_frames_o) |->
    $past(wr_i && addr_i == 8'h74); endproperty
  property p_fvr; $rose(frame_valid_o) |-> $past(fr_end_i); endproperty
  property p_fvf; $fell(frame_valid_o) |->
    $past(wr_i && addr_i == 8'h7e); endproperty
  property p_st0; st_rd && !frame_valid_o |=> rdata_o == 0; endproperty
  property p_st1; st_rd && frame_valid_o |=> rdata_o[15]; endproperty
  property p_unm; rd_i && addr_i == 8'h7a |=> rdata_o == 0; endproperty
  a_idle: assert property (p_idle) else $error("stray data");
  a_tx: assert property (p_tx) else $error("free bytes");
  a_lite: assert property (p_lite) else $error("lite moved");
  a_pass: assert property (p_pass) else $error("pass moved");
  a_fvr: assert property (p_fvr) else $error("valid rose");
  a_fvf: assert property (p_fvf) else $error("valid fell");
  a_st0: assert property (p_st0) else $error("empty status");
  a_st1: assert property (p_st1) else $error("valid bit");
  a_unm: assert property (p_unm) else $error("unmapped read");
  c_fvr: cover property ($rose(frame_valid_o));
  c_st1: cover property (st_rd && frame_valid_o);
  c_fvf: cover property ($fell(frame_valid_o));
endmodule
bind rxfs_core rxfs_core_props #(.TXW(TXW)) u_props (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fr_end_i(fr_end_i),
  .tx_free_bytes_i(tx_free_bytes_i),
  .lite_udp_checksum_enable_o(lite_udp_checksum_enable_o),
  .pass_bad_frames_o(pass_bad_frames_o), .frame_valid_o(frame_valid_o));

// >>> testbench/rxfs_frame_src.sv
`timescale 1ns/1ns
// receive path stand-in: one frame summary per send
module rxfs_frame_src (
  // clock
  input wire clk_i,
  // frame summary
  output reg end_o,
  output reg [47:0] da_o,
  output reg [47:0] sa_o,
  output reg [15:0] lt_o,
  output reg [11:0] len_o,
  output reg [11:0] fl_o
);
  initial {end_o, da_o, sa_o, lt_o, len_o, fl_o} = 0;
  task send(input [47:0] d, s, input [15:0] l, input [11:0] n, f);
    begin
      @(posedge clk_i);
      {end_o, da_o, sa_o, lt_o, len_o, fl_o} <= {1'b1, d, s, l, n, f};
      @(posedge clk_i);
      end_o <= 1'b0;
      // summary no longer held: scramble it
      {da_o, sa_o, lt_o, len_o, fl_o} <= ~{d, s, l, n, f};
    end
  endtask
endmodule

// >>> testbench/test_rxfs_core.sv
`timescale 1ns/1ns
module test_rxfs_core;
  // flag positions in the source vector
  localparam [11:0] CR = 12'h800, SY = 12'h400, RU = 12'h200;
  localparam [11:0] UD = 12'h100, LI = 12'h080, IC = 12'h040;
  localparam [11:0] FR = 12'h020, UZ = 12'h010, IB = 12'h008;
  localparam [11:0] PB = 12'h004, TB = 12'h002, UB = 12'h001;
  localparam [47:0] ST = 48'h0a12_3456_789a, OT = 48'h0a00_0000_0001;
  localparam [47:0] BC = 48'hffff_ffff_ffff, MC = 48'h0100_0000_0005;
  localparam [15:0] E = 16'h0800;
  reg sys_clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0;
  reg [7:0] addr_i = 0;
  reg [15:0] wdata_i = 0;
  reg [12:0] txf = 13'h1abc;
  wire [15:0] rdata_o;
  wire lite_o, pass_o, fv_o, irq_o, fe;
  wire [47:0] da, sa;
  wire [15:0] lt;
  wire [11:0] len, fl;
  integer err_count = 0, comparisons = 0, cyc = 0, i;
  always #5 sys_clk_i = ~sys_clk_i;
  rxfs_frame_src u_src (.clk_i(sys_clk_i), .end_o(fe), .da_o(da),
    .sa_o(sa), .lt_o(lt), .len_o(len), .fl_o(fl));
  rxfs_core uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .fr_end_i(fe), .fr_sa_i(sa), .fr_da_i(da),
    .fr_lentype_i(lt), .fr_len_i(len), .fr_crc_err_i(fl[11]),
    .fr_sym_err_i(fl[10]), .fr_runt_i(fl[9]), .fr_is_udp_i(fl[8]),
    .fr_is_lite_i(fl[7]), .fr_is_icmp_i(fl[6]), .fr_is_frag_i(fl[5]),
    .fr_udp_zero_i(fl[4]), .fr_icmp_bad_i(fl[3]), .fr_ip_bad_i(fl[2]),
    .fr_tcp_bad_i(fl[1]), .fr_udp_bad_i(fl[0]), .station_addr_i(ST),
    .tx_free_bytes_i(txf), .lite_udp_checksum_enable_o(lite_o),
    .pass_bad_frames_o(pass_o), .frame_valid_o(fv_o), .irq_o(irq_o));
  task final_report;
    begin
      $display("compares %0d wrong %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [15:0] s, e);
    begin
      comparisons = comparisons + 1;
      if (s !== e)
      begin
        err_count = err_count + 1;
        $display("wrong value at %0t: %h not %h", $time, s, e);
      end
    end
  endtask
  // one-cycle register strobes
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge sys_clk_i);
      {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [15:0] e);
    begin
      @(posedge sys_clk_i);
      {addr_i, rd_i} <= {a, 1'b1};
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 chk(rdata_o, e);
    end
  endtask
  // controls, one frame, status read, pop when stored
  task frm(input [3:0] c, input p, input [47:0] d, s, input [15:0] l,
    input [11:0] n, f, input [15:0] e);
    begin
      wr(8'h76, {12'h000, c});
      #1 chk({15'h0, lite_o}, {15'h0, c[2]});
      wr(8'h74, {6'h00, p, 9'h000});
      #1 chk({15'h0, pass_o}, {15'h0, p});
      u_src.send(d, s, l, n, f);
      rd(8'h7c, e);
      if (e != 0)
        wr(8'h7e, 16'h0000);
    end
  endtask
  // hang guard
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count = err_count + 1;
      final_report;
    end
  end
  initial
  begin
    repeat (12) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    rd(8'h76, 16'h0004);
    chk({15'h0, lite_o}, 16'h0001);
    rd(8'h74, 0);
    chk({15'h0, pass_o}, 0);
    rd(8'h7c, 0);
    rd(8'h78, 16'h1abc);
    rd(8'h7a, 0);
    txf <= 13'h0123;
    rd(8'h78, 16'h0123);
    $display("test reset done");
    frm(4, 0, ST, OT, E, 64, 0, 16'h8028);
    frm(4, 0, BC, OT, 16'h05dc, 64, 0, 16'h80c0);
    frm(4, 0, MC, OT, 16'h05dd, 64, 0, 16'h8048);
    frm(4, 0, ST, OT, E, 64, CR, 0);
    frm(4, 1, ST, OT, E, 64, CR, 16'h8029);
    frm(4, 0, ST, OT, E, 2001, 0, 0);
    frm(4, 1, ST, OT, E, 2001, 0, 16'h802c);
    frm(4, 0, ST, OT, 16'h0040, 64, RU, 0);
    frm(4, 1, ST, OT, 16'h0040, 64, RU, 16'h8022);
    frm(5, 0, ST, ST, E, 64, 0, 0);
    frm(4, 0, ST, ST, E, 64, 0, 16'h8028);
    frm(4, 0, ST, OT, E, 64, UD | UZ, 0);
    frm(12, 0, ST, OT, E, 64, UD | UZ, 16'h8028);
    frm(6, 0, ST, OT, E, 64, IC | IB, 0);
    frm(6, 0, ST, OT, E, 64, IC | IB | FR, 16'ha028);
    frm(4, 0, ST, OT, E, 64, UD | LI | UB, 16'h8428);
    frm(0, 0, ST, OT, E, 64, UD | LI | UB, 16'h8028);
    frm(4, 0, ST, OT, E, 64, SY | PB | TB, 16'h9838);
    $display("test frames done");
    wr(8'h92, 0);
    wr(8'h90, 3);
    for (i = 0; i < 5; i = i + 1)
      u_src.send(ST, OT, E, 64, 0);
    repeat (2) @(posedge sys_clk_i);
    #1 chk({15'h0, irq_o}, 0);
    wr(8'h92, 3);
    repeat (2) @(posedge sys_clk_i);
    #1 chk({15'h0, irq_o}, 1);
    rd(8'h90, 3);
    wr(8'h90, 3);
    repeat (2) @(posedge sys_clk_i);
    #1 chk({15'h0, irq_o}, 0);
    for (i = 0; i < 4; i = i + 1)
      frm(4, 0, ST, OT, E, 64, CR, 16'h8028);
    rd(8'h7c, 0);
    $display("test queue done");
    final_report;
  end
endmodule
